/* File: design/opdec_pkg.sv */
// package: opcode decoder constants and carrier types
package opdec_pkg;
  // ****************
  // register and condition codes
  // ****************
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  localparam logic [1:0] PAIR_BC = 2'h0;
  localparam logic [1:0] PAIR_DE = 2'h1;
  localparam logic [1:0] PAIR_HL = 2'h2;
  localparam logic [1:0] PAIR_AF = 2'h3;
  localparam logic [2:0] COND_NZ = 3'h0;
  localparam logic [2:0] COND_Z = 3'h1;
  localparam logic [2:0] COND_NC = 3'h2;
  localparam logic [2:0] COND_C = 3'h3;
  localparam logic [2:0] COND_PO = 3'h4;
  localparam logic [2:0] COND_PE = 3'h5;
  localparam logic [2:0] COND_P = 3'h6;
  localparam logic [2:0] COND_M = 3'h7;
  // ****************
  // fixed opcodes
  // ****************
  localparam logic [7:0] OP_PAIR_SWAP = 8'heb;
  localparam logic [7:0] OP_CALL = 8'hcd;
  localparam logic [7:0] OP_HL_TO_PC = 8'he9;
  // ****************
  // state counts
  // ****************
  localparam logic [4:0] ST_COPY = 5'h05;
  localparam logic [4:0] ST_MEM = 5'h07;
  localparam logic [4:0] ST_SWAP = 5'h04;
  localparam logic [4:0] ST_PUSH = 5'h0b;
  localparam logic [4:0] ST_POP = 5'h0a;
  localparam logic [4:0] ST_EXIT_NO = 5'h05;
  localparam logic [4:0] ST_EXIT_YES = 5'h0b;
  localparam logic [4:0] ST_CALL_NO = 5'h0b;
  localparam logic [4:0] ST_CALL_YES = 5'h11;
  localparam logic [4:0] ST_RESTART = 5'h0b;
  localparam logic [4:0] ST_HL_PC = 5'h05;
  localparam logic [4:0] ST_NONE = 5'h00;
  // ****************
  // carrier types
  // ****************
  typedef enum logic [3:0] {
    K_NONE, K_COPY, K_STORE, K_LOAD, K_SWAP, K_PUSH, K_POP, K_RETC, K_CALL, K_CALLC, K_RESTART, K_HLPC
  } op_kind_e;
  typedef struct packed {
    logic sign;
    logic zero;
    logic parity;
    logic carry;
  } flags_s;
  typedef struct packed {
    op_kind_e kind;
    logic [2:0] destRegField;
    logic [2:0] srcRegField;
    logic [1:0] pairSelectField;
    logic [2:0] conditionField;
    logic taken;
    logic [4:0] states;
    logic [15:0] target;
  } decode_s;
endpackage : opdec_pkg

/* File: design/byte_opcode_decoder_timing.sv */
// design: single-byte opcode decoder with state counts
`timescale 1ns/1ps

// Overview of operation
// [RULE1] 01, dest field, source field copies a register, 5 states
// [RULE2] 01110 then source field stores the register at address in h/l, 7 states; the code decodes 01110110 as none, 0 states
// [RULE3] 01, dest field, 110 loads destination from address in h/l, 7 states
// [RULE4] 11101011 swaps d/e with h/l in 4 states, flags untouched
// [RULE5] 11, pair field, 0101 pushes the selected pair, 11 states; b/c is 11000101
// [RULE6] h/l push 11100101, accumulator-flags push 11110101, both 11 states
// [RULE7] 11, pair field, 0001 pops the selected pair in 10 states; b/c is 11000001
// [RULE8] pair field bits 5:4 select bc, de, hl, accumulator-flags
// [RULE9] 11, condition field, 000 exits conditionally: 5 states not taken, 11 taken
// [RULE10] condition field: nz, z, nc, c, po, pe, p, m in order
// [RULE11] call 11001101 17 states; 11, condition field, 100: 11 not taken, 17 taken
// [RULE12] restart 11aaa111 11 states; 11101001 loads pc from h/l, 5 states
// [RULE13] restart target is eight times bits 5:3, other bits zero
// [RULE14] register field b,c,d,e,h,l,a; code 110 is memory via h/l
// [RULE15] shorter count when condition false, longer when true
module byte_opcode_decoder_timing (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fetched opcode from program memory
  input wire logic opValid,
  input wire logic [7:0] opByte,
  input wire opdec_pkg::flags_s flags,
  // decode result
  output opdec_pkg::decode_s decode,
  output logic decodeValid
);
  import opdec_pkg::*;

  // ****************
  // condition test
  // ****************
  function automatic logic condHolds(input logic [2:0] c, input flags_s f);
    logic r;
    r = 1'b0;
    unique case (c)
      COND_NZ: r = !f.zero; // RULE10
      COND_Z: r = f.zero;
      COND_NC: r = !f.carry;
      COND_C: r = f.carry;
      COND_PO: r = !f.parity;
      COND_PE: r = f.parity;
      COND_P: r = !f.sign;
      COND_M: r = f.sign;
    endcase
    return r;
  endfunction : condHolds

  // ****************
  // decode
  // ****************
  decode_s decode_r;
  decode_s decode_nxt;
  logic decodeValid_r;
  logic decodeValid_nxt;
  decode_s d;
  logic hit;

  always_comb begin
    d = '0;
    d.kind = K_NONE;
    d.destRegField = opByte[5:3];
    d.srcRegField = opByte[2:0];
    d.pairSelectField = opByte[5:4]; // RULE8
    d.conditionField = opByte[5:3];
    d.states = ST_NONE;
    hit = condHolds(opByte[5:3], flags);
    if (opByte[7:6] == 2'h1 && opByte != 8'h76) begin
      if (opByte[5:3] == REG_MEM) begin
        d.kind = K_STORE; // RULE2 RULE14
        d.states = ST_MEM;
      end else if (opByte[2:0] == REG_MEM) begin
        d.kind = K_LOAD; // RULE3 RULE14
        d.states = ST_MEM;
      end else begin
        d.kind = K_COPY; // RULE1
        d.states = ST_COPY;
      end
    end else if (opByte == OP_PAIR_SWAP) begin
      d.kind = K_SWAP; // RULE4
      d.states = ST_SWAP;
    end else if (opByte == OP_CALL) begin
      d.kind = K_CALL; // RULE11
      d.states = ST_CALL_YES;
      d.taken = 1'b1;
    end else if (opByte == OP_HL_TO_PC) begin
      d.kind = K_HLPC; // RULE12
      d.states = ST_HL_PC;
      d.taken = 1'b1;
    end else if (opByte[7:6] == 2'h3) begin
      unique case (opByte[3:0])
        4'h5, 4'hd: begin
          if (!opByte[3]) begin
            d.kind = K_PUSH; // RULE5 RULE6
            d.states = ST_PUSH;
          end
        end
        4'h1, 4'h9: begin
          if (!opByte[3]) begin
            d.kind = K_POP; // RULE7
            d.states = ST_POP;
          end
        end
        4'h0, 4'h8: begin
          d.kind = K_RETC; // RULE9
          d.taken = hit;
          d.states = hit ? ST_EXIT_YES : ST_EXIT_NO; // RULE15
        end
        4'h4, 4'hc: begin
          d.kind = K_CALLC; // RULE11
          d.taken = hit;
          d.states = hit ? ST_CALL_YES : ST_CALL_NO; // RULE15
        end
        4'h7, 4'hf: begin
          d.kind = K_RESTART; // RULE12
          d.taken = 1'b1;
          d.states = ST_RESTART;
          d.target = {10'h000, opByte[5:3], 3'h0}; // RULE13
        end
        default: d.kind = K_NONE;
      endcase
    end
    decode_nxt = opValid ? d : decode_r;
    decodeValid_nxt = opValid;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      decode_r <= '0;
      decodeValid_r <= 1'b0;
    end else begin
      decode_r <= decode_nxt;
      decodeValid_r <= decodeValid_nxt;
    end
  end

  assign decode = decode_r;
  assign decodeValid = decodeValid_r;

  // ****************
  // fetch and answer sequences
  // ****************
  sequence s_fetch_push;
    opValid && opByte[7:6] == 2'h3 && opByte[3:0] == 4'h5;
  endsequence
  sequence s_fetch_pop;
    opValid && opByte[7:6] == 2'h3 && opByte[3:0] == 4'h1;
  endsequence
  sequence s_fetch_callc;
    opValid && opByte[7:6] == 2'h3 && opByte[2:0] == 3'h4;
  endsequence
  sequence s_fetch_restart;
    opValid && opByte[7:6] == 2'h3 && opByte[2:0] == 3'h7;
  endsequence
  sequence s_reg_fields;
    decodeValid && decode.destRegField == $past(opByte[5:3]) && decode.srcRegField == $past(opByte[2:0]);
  endsequence

  // ****************
  // checks
  // ****************
  a_copy_states: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    opValid && opByte[7:6] == 2'h1 && opByte[5:3] != 3'h6 && opByte[2:0] != 3'h6
    |=> decodeValid && decode.kind == K_COPY && decode.states == 5'h05) else $error("copy decode wrong");
  a_store_states: assert property (@(posedge clk) disable iff (!rstn) // RULE2
    opValid && opByte[7:3] == 5'h0e && opByte[2:0] != 3'h6
    |=> decode.kind == K_STORE && decode.states == 5'h07) else $error("store decode wrong");
  a_halt_refused: assert property (@(posedge clk) disable iff (!rstn) // RULE2
    opValid && opByte == 8'h76 |=> decode.kind == K_NONE && decode.states == 5'h00) else $error("halt decoded");
  a_load_states: assert property (@(posedge clk) disable iff (!rstn) // RULE3
    opValid && opByte[7:6] == 2'h1 && opByte[2:0] == 3'h6 && opByte[5:3] != 3'h6
    |=> decode.kind == K_LOAD && decode.states == 5'h07) else $error("load decode wrong");
  a_reg_fields: assert property (@(posedge clk) disable iff (!rstn) // RULE14
    opValid && opByte[7:6] == 2'h1 |=> s_reg_fields) else $error("register fields wrong");
  a_swap_states: assert property (@(posedge clk) disable iff (!rstn) // RULE4
    opValid && opByte == 8'heb |=> decode.kind == K_SWAP && decode.states == 5'h04) else $error("swap wrong");
  a_push_states: assert property (@(posedge clk) disable iff (!rstn) // RULE5
    s_fetch_push |=> decode.kind == K_PUSH && decode.states == 5'h0b
    && decode.pairSelectField == $past(opByte[5:4]))
    else $error("push wrong");
  a_push_hl: assert property (@(posedge clk) disable iff (!rstn) // RULE6
    opValid && opByte == 8'he5 |=> decode.kind == K_PUSH && decode.pairSelectField == 2'h2 && decode.states == 5'h0b)
    else $error("pair h/l push wrong");
  a_push_acc_flags: assert property (@(posedge clk) disable iff (!rstn) // RULE6
    opValid && opByte == 8'hf5 |=> decode.kind == K_PUSH && decode.pairSelectField == 2'h3 && decode.states == 5'h0b)
    else $error("accumulator-flags push wrong");
  a_pop_states: assert property (@(posedge clk) disable iff (!rstn) // RULE7
    s_fetch_pop |=> decode.kind == K_POP && decode.states == 5'h0a) else $error("pop wrong");
  a_pop_pair: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    s_fetch_pop |=> decode.pairSelectField == $past(opByte[5:4])) else $error("pop pair field wrong");
  a_pop_acc_flags: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    opValid && opByte == 8'hf1 |=> decode.kind == K_POP && decode.pairSelectField == 2'h3 && decode.states == 5'h0a)
    else $error("accumulator-flags pop wrong");
  a_exit_parity_even: assert property (@(posedge clk) disable iff (!rstn) // RULE9
    opValid && opByte == 8'he8
    |=> decode.states == ($past(flags.parity) ? 5'h0b : 5'h05)) else $error("exit on parity even wrong");
  a_exit_zero: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    opValid && opByte == 8'hc8 |=> decode.kind == K_RETC && decode.taken == $past(flags.zero))
    else $error("exit on zero wrong");
  a_call_minus: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    opValid && opByte == 8'hfc |=> decode.taken == $past(flags.sign) && decode.conditionField == 3'h7)
    else $error("call on minus wrong");
  a_cond_field: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    s_fetch_callc |=> decode.kind == K_CALLC && decode.conditionField == $past(opByte[5:3]))
    else $error("condition field wrong");
  a_call_cond: assert property (@(posedge clk) disable iff (!rstn) // RULE11
    opValid && opByte == 8'hdc
    |=> decode.taken == $past(flags.carry) && decode.states == ($past(flags.carry) ? 5'h11 : 5'h0b))
    else $error("call on carry wrong");
  a_call_uncond: assert property (@(posedge clk) disable iff (!rstn) // RULE11
    opValid && opByte == 8'hcd |=> decode.kind == K_CALL && decode.taken && decode.states == 5'h11)
    else $error("call wrong");
  a_hl_to_pc: assert property (@(posedge clk) disable iff (!rstn) // RULE12
    opValid && opByte == 8'he9 |=> decode.kind == K_HLPC && decode.states == 5'h05) else $error("h/l to pc wrong");
  a_restart_target: assert property (@(posedge clk) disable iff (!rstn) // RULE13
    s_fetch_restart |=> decode.target == 16'h0008 * 16'($past(opByte[5:3])) && decode.states == 5'h0b)
    else $error("restart wrong");
  a_hold_idle: assert property (@(posedge clk) disable iff (!rstn) // RULE15
    !opValid |=> !decodeValid && $stable(decode)) else $error("decode changed while idle");
endmodule : byte_opcode_decoder_timing

/* File: testbench/opcode_source.sv */
// partner: program memory model handing out fetched opcode bytes
`timescale 1ns/1ps
module opcode_source (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fetch request from the bench
  input wire logic fetch,
  input wire logic [7:0] addr,
  // opcode toward the decoder
  output logic opValid,
  output logic [7:0] opByte
);
  // ****************
  // memory image: each byte holds its own address; an idle bus toggles
  // ****************
  logic opValid_r, opValid_nxt;
  logic [7:0] opByte_r, opByte_nxt;
  always_comb begin
    opValid_nxt = fetch;
    opByte_nxt = fetch ? addr : ~opByte_r;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opValid_r <= 1'b0;
      opByte_r <= 8'h00;
    end else begin
      opValid_r <= opValid_nxt;
      opByte_r <= opByte_nxt;
    end
  end
  assign opValid = opValid_r;
  assign opByte = opByte_r;
endmodule : opcode_source

/* File: testbench/testbench.sv */
// testbench: fetches opcodes through the memory model and checks decoding
`timescale 1ns/1ps
module testbench;
  import opdec_pkg::*;
  // ****************
  // signals and instances
  // ****************
  logic clk, rstn, fetch, opValid, decodeValid;
  logic [7:0] addr, opByte;
  flags_s flg;
  decode_s decode;
  int errors, checked, cyc;
  opcode_source i_opcode_source (.clk(clk), .rstn(rstn), .fetch(fetch), .addr(addr), .opValid(opValid),
    .opByte(opByte));
  byte_opcode_decoder_timing i_byte_opcode_decoder_timing (.clk(clk), .rstn(rstn), .opValid(opValid),
    .opByte(opByte), .flags(flg), .decode(decode), .decodeValid(decodeValid));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************
  // shared tasks
  // ****************
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic issue(logic [7:0] op, logic [3:0] fl, logic [3:0] k, logic [4:0] st);
    int n;
    @(posedge clk);
    fetch <= 1'b1;
    addr <= op;
    flg <= fl;
    @(posedge clk);
    fetch <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (decodeValid !== 1'b1 && n < 4);
    chk("decodeValid", {15'h0, decodeValid}, 16'h1);
    chk("kind", {12'h0, decode.kind}, {12'h0, k});
    chk("states", {11'h0, decode.states}, {11'h0, st});
  endtask : issue
  // ****************
  // scenarios
  // ****************
  task automatic t_move();
    logic [7:0] op;
    for (int i = 0; i < 64; i++) begin
      op = {2'h1, i[5:0]};
      if (op == 8'h76) issue(op, 4'h0, K_NONE, 5'h00);
      else if (op[5:3] == 3'h6) issue(op, 4'h0, K_STORE, 5'h07);
      else if (op[2:0] == 3'h6) issue(op, 4'h0, K_LOAD, 5'h07);
      else begin
        issue(op, 4'h0, K_COPY, 5'h05);
        chk("dest", {13'h0, decode.destRegField}, {13'h0, op[5:3]});
        chk("src", {13'h0, decode.srcRegField}, {13'h0, op[2:0]});
      end
    end
    $display("test move done");
  endtask : t_move
  task automatic t_stack();
    issue(8'heb, 4'hf, K_SWAP, 5'h04);
    for (int p = 0; p < 4; p++) begin
      issue({2'h3, p[1:0], 4'h5}, 4'h0, K_PUSH, 5'h0b);
      chk("pair", {14'h0, decode.pairSelectField}, p[15:0]);
      issue({2'h3, p[1:0], 4'h1}, 4'h0, K_POP, 5'h0a);
      chk("pair", {14'h0, decode.pairSelectField}, p[15:0]);
    end
    $display("test stack done");
  endtask : t_stack
  task automatic t_cond();
    logic [3:0] pos[4] = '{4'h4, 4'h1, 4'h2, 4'h8};
    logic [3:0] fl;
    logic t;
    for (int c = 0; c < 8; c++) begin
      for (int f = 0; f < 2; f++) begin
        fl = f[0] ? pos[c / 2] : ~pos[c / 2];
        t = (f[0] == c[0]);
        issue({2'h3, c[2:0], 3'h0}, fl, K_RETC, t ? 5'h0b : 5'h05);
        chk("taken", {15'h0, decode.taken}, {15'h0, t});
        chk("cond", {13'h0, decode.conditionField}, c[15:0]);
        issue({2'h3, c[2:0], 3'h4}, fl, K_CALLC, t ? 5'h11 : 5'h0b);
        chk("taken", {15'h0, decode.taken}, {15'h0, t});
      end
    end
    $display("test conditions done");
  endtask : t_cond
  task automatic t_branch();
    issue(8'hcd, 4'h0, K_CALL, 5'h11);
    chk("taken", {15'h0, decode.taken}, 16'h1);
    issue(8'he9, 4'h0, K_HLPC, 5'h05);
    for (int a = 0; a < 8; a++) begin
      issue({2'h3, a[2:0], 3'h7}, 4'h0, K_RESTART, 5'h0b);
      chk("target", decode.target, {10'h0, a[2:0], 3'h0});
    end
    issue(8'hed, 4'h0, K_NONE, 5'h00);
    $display("test branch done");
  endtask : t_branch
  // ****************
  // run control
  // ****************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    rstn = 1'b0;
    fetch = 1'b0;
    addr = 8'h00;
    flg = 4'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_move();
    t_stack();
    t_cond();
    t_branch();
    print_verdict();
  end
endmodule : testbench
